/* swbc_checker.sv */
// Purpose: Port checks for swbc_top
// Assumes: One clock, sync active-low reset
// Notes: Slot length follows the speed select
`timescale 1ns/1ns
`include "swbc_defs.svh"
module swbc_checker (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire swbc_pkg::swbc_byte_t i_cmd_code,
    input wire logic o_cmd_ack,
    input wire logic o_cmd_ready,
    input wire logic o_line_out,
    input wire logic i_strong_pullup_enable,
    input wire logic i_data_valid,
    input wire logic o_data_ack,
    input wire logic o_read_ptr,
    input wire logic o_line_busy_flag,
    input wire logic i_overdrive_speed_select,
    input wire logic i_active_pullup_enable,
    input wire logic [`SWBC_TIME_W-1:0] i_slot_std,
    input wire logic [`SWBC_TIME_W-1:0] i_slot_od,
    input wire logic o_line_oe,
    input wire logic o_active_pullup,
    input wire logic o_strong_pullup
);
    localparam int START_MAX = `SWBC_START_MAX_CYC;
    logic [15:0] busy_len;
    logic [`SWBC_TIME_W-1:0] slot;
    // Busy length in cycles
    assign slot = i_overdrive_speed_select ? i_slot_od : i_slot_std;
    always_ff @(posedge i_clk) begin
        busy_len <= o_line_busy_flag ? busy_len + 16'h1 : 16'h0;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    AST_BUSY_NO_ACK: assert property (o_line_busy_flag |-> !o_cmd_ack)
        else $error("code acked while busy");
    AST_BUSY_NO_DATA_ACK: assert property (i_data_valid && o_line_busy_flag |-> !o_data_ack)
        else $error("data acked while busy");
    AST_ACK_CODES: assert property (i_cmd_valid && o_cmd_ack |->
        i_cmd_code == `SWBC_CMD_WRITE_BYTE || i_cmd_code == `SWBC_CMD_READ_BYTE) else $error("bad code acked");
    AST_WRITE_START: assert property (i_data_valid && o_data_ack |->
        ##[1:START_MAX] (o_line_oe && o_line_busy_flag)) else $error("write start late");
    AST_READ_START: assert property (i_cmd_valid && o_cmd_ack && i_cmd_code == `SWBC_CMD_READ_BYTE |->
        ##[1:START_MAX] (o_line_oe && o_line_busy_flag)) else $error("read start late");
    AST_PTR_STATUS: assert property (i_cmd_valid && o_cmd_ack |=> !o_read_ptr)
        else $error("pointer not at status");
    AST_BUSY_LEN: assert property ($fell(o_line_busy_flag) |->
        busy_len >= 8 * slot && busy_len <= 8 * slot + 16) else $error("busy length wrong");
    AST_OE_IN_BUSY: assert property (o_line_oe |-> o_line_busy_flag)
        else $error("line pulled while idle");
    AST_APU_OFF: assert property (!i_active_pullup_enable |-> !o_active_pullup)
        else $error("active pullup while disabled");
    AST_NO_PULLUP_LOW: assert property (o_line_oe |-> !o_active_pullup && !o_strong_pullup)
        else $error("pullup while pulling low");
    AST_READY_ACK: assert property (i_cmd_valid && !o_cmd_ready |-> !o_cmd_ack)
        else $error("code acked while not ready");
    AST_LINE_LOW_ONLY: assert property (o_line_oe |-> !o_line_out)
        else $error("line driven high");
    AST_SPU_GATED: assert property (o_strong_pullup |-> i_strong_pullup_enable && o_line_busy_flag)
        else $error("strong pullup not enabled");
endmodule
bind swbc_top swbc_checker i_swbc_checker (.i_clk, .i_resetn, .i_cmd_valid, .i_cmd_code, .o_cmd_ack,
    .o_cmd_ready, .o_line_out, .i_strong_pullup_enable,
    .i_data_valid, .o_data_ack, .o_read_ptr, .o_line_busy_flag, .i_overdrive_speed_select,
    .i_active_pullup_enable, .i_slot_std, .i_slot_od, .o_line_oe, .o_active_pullup, .o_strong_pullup);

/* swbc_defs.svh */
// Purpose: Constants for the single-wire byte command engine
// Assumes: 20 MHz clock (50 ns period)
// Notes: Slot timing comes in as cycle counts from port configuration
`ifndef SWBC_DEFS_SVH
`define SWBC_DEFS_SVH
`define SWBC_CMD_WRITE_BYTE 8'ha5
`define SWBC_CMD_READ_BYTE 8'h96
`define SWBC_START_MAX_PS 262500
`define SWBC_CLK_PERIOD_PS 50000
`define SWBC_START_MAX_CYC ((`SWBC_START_MAX_PS) / (`SWBC_CLK_PERIOD_PS))
`define SWBC_SLOTS_PER_BYTE 4'h8
`define SWBC_PTR_STATUS 1'b0
`define SWBC_PTR_READ_DATA 1'b1
`define SWBC_TIME_W 12
`define SWBC_FIFO_DEPTH 8
`endif

/* swbc_fifo.sv */
// Purpose: Small synchronous FIFO for command bytes
// Assumes: Single clock, synchronous active-low reset
// Notes: Storage in flip-flops
`timescale 1ns/1ns
module swbc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // Handshakes and pointer updates
    always_comb begin
        o_in_ready = (count != (AW+1)'(DEPTH));
        o_out_valid = (count != '0);
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    // Register pointers and storage
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    assign o_out_data = mem[rd_ptr];
endmodule

/* swbc_pkg.sv */
// Purpose: Types for the single-wire byte command engine
// Assumes: Used with swbc_defs.svh
// Notes: One-hot state codes
package swbc_pkg;
    typedef enum logic [3:0] {
        SWBC_IDLE = 4'h1,
        SWBC_LOW = 4'h2,
        SWBC_RELEASE = 4'h4,
        SWBC_RECOVER = 4'h8
    } swbc_state_e;
    typedef logic [7:0] swbc_byte_t;
endpackage

/* swbc_slave_model.sv */
// Purpose: Line slave that decodes slots and returns bits
// Assumes: Line has a pull-up, low pulse under 10 cycles is a one
// Notes: Pulls low 12 cycles for each returned zero
`timescale 1ns/1ns
module swbc_slave_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_line_oe,
    input wire logic [7:0] i_tx_byte,
    output logic o_pull,
    output logic [7:0] o_rx_byte
);
    logic [4:0] low_cnt;
    logic [4:0] pull_cnt;
    logic [2:0] idx;
    logic oe_d;
    // Slot decode and bit return
    always_ff @(posedge i_clk) begin
        oe_d <= i_line_oe;
        if (!i_resetn) begin
            idx <= 3'h0;
            pull_cnt <= 5'h00;
            low_cnt <= 5'h00;
            o_rx_byte <= 8'h00;
        end else begin
            if (i_line_oe) low_cnt <= low_cnt + 5'h01;
            if (i_line_oe && !oe_d) begin
                pull_cnt <= i_tx_byte[idx] ? 5'h00 : 5'h0c;
                idx <= idx + 3'h1;
                low_cnt <= 5'h01;
            end else if (pull_cnt != 5'h00) begin
                pull_cnt <= pull_cnt - 5'h01;
            end
            if (!i_line_oe && oe_d) o_rx_byte <= {low_cnt < 5'h0a, o_rx_byte[7:1]};
        end
    end
    assign o_pull = pull_cnt != 5'h00;
endmodule

/* swbc_tb_top.sv */
// Purpose: Self-checking bench for swbc_top
// Assumes: 20 MHz clock, inputs change at falling edge
// Notes: Slave model decodes and answers slots
`timescale 1ns/1ns
`include "swbc_defs.svh"
module swbc_tb_top;
    import swbc_pkg::*;
    logic i_clk = 0, i_resetn = 0, i_cmd_valid = 0, i_data_valid = 0, i_set_ptr_read_data = 0;
    logic i_overdrive_speed_select = 0, i_strong_pullup_enable = 1, i_active_pullup_enable = 1;
    swbc_byte_t i_cmd_code = 8'h00, i_data_byte = 8'h00, tx_byte = 8'hff, o_read_data, rx_byte;
    logic [11:0] i_slot_std = 12'h028, i_slot_od = 12'h01e, i_read_sample_time = 12'h006;
    logic o_cmd_ack, o_data_ack, o_read_ptr, o_line_busy_flag, o_line_oe, pull;
    int errors = 0;
    int n_compared = 0;
    wire line = ~(o_line_oe | pull);
    initial forever #25 i_clk = ~i_clk;
    swbc_top i_swbc_top (.i_clk, .i_resetn, .i_cmd_valid, .i_cmd_code, .o_cmd_ack, .i_data_valid,
        .i_data_byte, .o_data_ack, .o_cmd_ready(), .o_read_ptr, .i_set_ptr_read_data, .o_read_data,
        .o_line_busy_flag, .i_overdrive_speed_select, .i_strong_pullup_enable, .i_active_pullup_enable,
        .i_slot_std, .i_slot_od, .i_low_one_std(12'h002), .i_low_one_od(12'h001),
        .i_write_zero_low_duration(12'h014), .i_read_sample_time, .i_line(line), .o_line_out(),
        .o_line_oe, .o_active_pullup(), .o_strong_pullup());
    swbc_slave_model i_swbc_slave_model (.i_clk, .i_resetn, .i_line_oe(o_line_oe), .i_tx_byte(tx_byte),
        .o_pull(pull), .o_rx_byte(rx_byte));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task automatic results();
        $display("errors %0d n_compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One byte strobe, ack judged in its cycle
    task automatic send(input logic data, input swbc_byte_t b, input logic ack);
        @(negedge i_clk);
        {i_cmd_valid, i_data_valid, i_cmd_code, i_data_byte} = {!data, data, b, b};
        #1;
        chk("ack", {7'h0, ack}, {7'h0, data ? o_data_ack : o_cmd_ack});
        @(negedge i_clk);
        {i_cmd_valid, i_data_valid} = 2'b00;
    endtask
    task automatic wait_busy(input logic lvl);
        int k;
        for (k = 0; k < 600 && o_line_busy_flag !== lvl; k++) @(negedge i_clk);
        chk("busy", {7'h0, lvl}, {7'h0, o_line_busy_flag});
        if (o_line_busy_flag !== lvl) results();
    endtask
    task automatic t_write(input swbc_byte_t b, input logic od);
        i_overdrive_speed_select = od;
        tx_byte = 8'hff;
        send(0, `SWBC_CMD_WRITE_BYTE, 1);
        send(1, b, 1);
        wait_busy(1);
        chk("ptr", 8'h00, {7'h0, o_read_ptr});
        wait_busy(0);
        chk("written", b, rx_byte);
    endtask
    task automatic t_read(input swbc_byte_t b);
        tx_byte = b;
        send(0, `SWBC_CMD_READ_BYTE, 1);
        wait_busy(1);
        chk("ptr", 8'h00, {7'h0, o_read_ptr});
        wait_busy(0);
        chk("read data", b, o_read_data);
        chk("read slots", 8'hff, rx_byte);
        i_set_ptr_read_data = 1;
        @(negedge i_clk);
        i_set_ptr_read_data = 0;
        chk("ptr", 8'h01, {7'h0, o_read_ptr});
    endtask
    task automatic t_refuse();
        {i_active_pullup_enable, i_slot_std, i_read_sample_time} = {1'b0, 12'h024, 12'h007};
        tx_byte = 8'hff;
        send(0, `SWBC_CMD_WRITE_BYTE, 1);
        send(1, 8'he7, 1);
        wait_busy(1);
        send(0, `SWBC_CMD_WRITE_BYTE, 0);
        send(1, 8'h18, 0);
        send(0, `SWBC_CMD_READ_BYTE, 0);
        wait_busy(0);
        chk("written", 8'he7, rx_byte);
        send(0, 8'h3c, 0);
        send(1, 8'h3c, 0);
        i_active_pullup_enable = 1;
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_resetn = 1;
        t_write(8'h01, 0);
        t_write(8'h80, 0);
        t_read(8'h00);
        t_read(8'hc3);
        t_write(8'h5a, 1);
        t_read(8'h69);
        t_refuse();
        results();
    end
endmodule

/* swbc_top.sv */
// Purpose: Byte write and byte read commands on a single-wire line
// Assumes: I2C front end gives decoded bytes and takes ack decisions on i_clk
// Notes: Slot timing is given in clock cycles by port configuration
`timescale 1ns/1ns
`include "swbc_defs.svh"
module swbc_top (
    input wire logic i_clk,
    input wire logic i_resetn,
    // I2C side: command code and data byte strobes
    input wire logic i_cmd_valid,
    input wire swbc_pkg::swbc_byte_t i_cmd_code,
    output logic o_cmd_ack,
    input wire logic i_data_valid,
    input wire swbc_pkg::swbc_byte_t i_data_byte,
    output logic o_data_ack,
    output logic o_cmd_ready,
    output logic o_read_ptr,
    input wire logic i_set_ptr_read_data,
    output swbc_pkg::swbc_byte_t o_read_data,
    output logic o_line_busy_flag,
    // Configuration
    input wire logic i_overdrive_speed_select,
    input wire logic i_strong_pullup_enable,
    input wire logic i_active_pullup_enable,
    input wire logic [`SWBC_TIME_W-1:0] i_slot_std,
    input wire logic [`SWBC_TIME_W-1:0] i_slot_od,
    input wire logic [`SWBC_TIME_W-1:0] i_low_one_std,
    input wire logic [`SWBC_TIME_W-1:0] i_low_one_od,
    input wire logic [`SWBC_TIME_W-1:0] i_write_zero_low_duration,
    input wire logic [`SWBC_TIME_W-1:0] i_read_sample_time,
    // Single-wire line
    input wire logic i_line,
    output logic o_line_out,
    output logic o_line_oe,
    output logic o_active_pullup,
    output logic o_strong_pullup
);
    import swbc_pkg::*;

    logic line_s1, line_s2;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [8:0] fifo_in_data, fifo_out_data;
    swbc_state_e state, next_state;
    logic line_busy_flag, next_line_busy_flag;
    logic pend_write, next_pend_write;
    logic is_read, next_is_read;
    logic strong_en, next_strong_en;
    logic read_ptr, next_read_ptr;
    swbc_byte_t shift, next_shift;
    swbc_byte_t read_data, next_read_data;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [`SWBC_TIME_W-1:0] tcnt, next_tcnt;
    logic [`SWBC_TIME_W-1:0] slot_len, low_len;
    logic cmd_ok;

    // ---------------------------------------------------------------
    // Line input synchroniser
    // ---------------------------------------------------------------
    // Two flops before any use of the line level
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            line_s1 <= 1'b1;
            line_s2 <= 1'b1;
        end else begin
            line_s1 <= i_line;
            line_s2 <= line_s1;
        end
    end

    // ---------------------------------------------------------------
    // Command intake
    // ---------------------------------------------------------------
    // Accept a command only while idle and FIFO has room
    always_comb begin
        // A queued byte counts as busy, so nothing slips in before the flag rises
        cmd_ok = !line_busy_flag && !pend_write && !fifo_out_valid && fifo_in_ready;
        o_cmd_ready = cmd_ok;
        o_cmd_ack = i_cmd_valid && cmd_ok &&
            (i_cmd_code == `SWBC_CMD_WRITE_BYTE || i_cmd_code == `SWBC_CMD_READ_BYTE);
        o_data_ack = i_data_valid && pend_write && fifo_in_ready;
        fifo_in_valid = 1'b0;
        fifo_in_data = 9'h000;
        next_pend_write = pend_write;
        next_read_ptr = read_ptr;
        if (i_set_ptr_read_data) begin
            next_read_ptr = `SWBC_PTR_READ_DATA;
        end
        if (o_cmd_ack) begin
            next_read_ptr = `SWBC_PTR_STATUS;
            if (i_cmd_code == `SWBC_CMD_READ_BYTE) begin
                fifo_in_valid = 1'b1;
                fifo_in_data = {1'b1, 8'hff};
            end else begin
                next_pend_write = 1'b1;
            end
        end
        if (o_data_ack) begin
            // Whole byte held, LSB sent first later
            fifo_in_valid = 1'b1;
            fifo_in_data = {1'b0, i_data_byte};
            next_pend_write = 1'b0;
        end
    end

    swbc_fifo #(.WIDTH(9), .DEPTH(`SWBC_FIFO_DEPTH)) i_swbc_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    // ---------------------------------------------------------------
    // Slot engine
    // ---------------------------------------------------------------
    // Slot length and one-bit low time set by speed select
    always_comb begin
        slot_len = i_overdrive_speed_select ? i_slot_od : i_slot_std;
        if (shift[0]) begin
            low_len = i_overdrive_speed_select ? i_low_one_od : i_low_one_std;
        end else begin
            low_len = i_write_zero_low_duration;
        end
    end

    // Eight slots per byte, LSB first
    always_comb begin
        next_state = state;
        next_line_busy_flag = line_busy_flag;
        next_is_read = is_read;
        next_strong_en = strong_en;
        next_shift = shift;
        next_read_data = read_data;
        next_bit_cnt = bit_cnt;
        next_tcnt = `SWBC_TIME_W'(tcnt + 1'b1);
        fifo_out_ready = 1'b0;
        case (state)
            SWBC_IDLE: begin
                next_tcnt = '0;
                if (fifo_out_valid) begin
                    fifo_out_ready = 1'b1;
                    // Start next cycle, well inside 262.5ns
                    next_state = SWBC_LOW;
                    next_line_busy_flag = 1'b1;
                    next_is_read = fifo_out_data[8];
                    next_strong_en = !fifo_out_data[8] && i_strong_pullup_enable;
                    next_shift = fifo_out_data[7:0];
                    next_bit_cnt = '0;
                end
            end
            SWBC_LOW: begin
                if (next_tcnt >= low_len) begin
                    next_state = SWBC_RELEASE;
                end
            end
            SWBC_RELEASE: begin
                // At or past the sample point, so a long zero low cannot skip it
                if (tcnt >= i_read_sample_time) begin
                    next_state = SWBC_RECOVER;
                    // Sampled bit enters at the top, lands LSB first
                    if (is_read) begin
                        next_read_data = {line_s2, read_data[7:1]};
                    end
                end
            end
            SWBC_RECOVER: begin
                if (next_tcnt >= slot_len) begin
                    next_tcnt = '0;
                    next_shift = {1'b0, shift[7:1]};
                    next_bit_cnt = 4'(bit_cnt + 1'b1);
                    if (next_bit_cnt == `SWBC_SLOTS_PER_BYTE) begin
                        next_state = SWBC_IDLE;
                        next_line_busy_flag = 1'b0;
                    end else begin
                        next_state = SWBC_LOW;
                    end
                end
            end
            default: begin
                next_state = SWBC_IDLE;
                next_line_busy_flag = 1'b0;
            end
        endcase
    end

    // Register engine and intake state
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= SWBC_IDLE;
            line_busy_flag <= 1'b0;
            pend_write <= 1'b0;
            is_read <= 1'b0;
            strong_en <= 1'b0;
            read_ptr <= `SWBC_PTR_STATUS;
            shift <= 8'h00;
            read_data <= 8'h00;
            bit_cnt <= 4'h0;
            tcnt <= '0;
        end else begin
            state <= next_state;
            line_busy_flag <= next_line_busy_flag;
            pend_write <= next_pend_write;
            is_read <= next_is_read;
            strong_en <= next_strong_en;
            read_ptr <= next_read_ptr;
            shift <= next_shift;
            read_data <= next_read_data;
            bit_cnt <= next_bit_cnt;
            tcnt <= next_tcnt;
        end
    end

    // Line drive and pullup controls
    assign o_line_out = 1'b0;
    assign o_line_oe = (state == SWBC_LOW);
    assign o_active_pullup = i_active_pullup_enable && (state != SWBC_LOW);
    // Strong pullup helps write slots recover, never while pulling low
    assign o_strong_pullup = strong_en && (state == SWBC_RECOVER);
    assign o_line_busy_flag = line_busy_flag;
    assign o_read_data = read_data;
    assign o_read_ptr = read_ptr;
endmodule
